// >>> rtl/timer_pwm_channel_logic.sv
/*
 * Two-channel 16-bit timer core: counter, flags, buffered pair, pins.
 * Assumes all control ports come from logic on clk_i and are held
 * steady by software between its accesses.
 */
module timer_pwm_channel_logic import timer_pkg::*; (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             counter_halt_bit_i,
	input  wire logic             counter_clear_i,
	input  wire logic [2:0]       prescale_sel_i,
	input  wire logic [CNT_W-1:0] period_limit_i,
	input  wire logic             wrap_irq_enable_i,
	input  wire logic [1:0]       cmp_wr_i,
	input  wire logic [CNT_W-1:0] cmp_data_i,
	input  wire logic             pair_link_bit_i,
	input  wire logic [1:0]       single_channel_select_i,
	input  wire logic [1:0]       edge_level_select0_i,
	input  wire logic [1:0]       edge_level_select1_i,
	input  wire logic [1:0]       wrap_toggle_enable_i,
	input  wire logic [1:0]       full_duty_select_i,
	input  wire logic [1:0]       channel_irq_enable_i,
	input  wire logic             wrap_flag_read_i,
	input  wire logic             wrap_flag_clear_i,
	input  wire logic [1:0]       chan_flag_read_i,
	input  wire logic [1:0]       chan_flag_clear_i,
	input  wire logic             wait_mode_i,
	input  wire logic             stop_mode_i,
	input  wire logic             break_i,
	input  wire logic             break_clear_permit_i,
	output logic [CNT_W-1:0]      counter_value_o,
	output logic                  wrap_flag_o,
	output logic [1:0]            channel_event_flag_o,
	output logic                  wrap_irq_o,
	output logic [1:0]            chan_irq_o,
	output logic                  wake_o,
	output logic                  active_pair_o,
	output logic                  first_channel_pin_o,
	output logic                  first_channel_pin_oe_o,
	output logic                  second_channel_pin_o,
	output logic                  second_channel_pin_oe_o
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             wrap_flag;
		logic             wrap_arm;
		logic [1:0]       ch_flag;
		logic [1:0]       ch_arm;
		logic [CNT_W-1:0] cmp0;
		logic [CNT_W-1:0] cmp1;
		logic             act_sel;
		logic             last_sel;
	} core_state_t;

	core_state_t      st_reg;
	core_state_t      st_next;
	logic             tick;
	logic             run;
	logic             access_ok;
	logic             clear_ok;
	logic             at_limit;
	logic             wrap_ev;
	logic             linked;
	logic [CNT_W-1:0] cmp_a;
	logic [1:0]       out_mode;
	logic [1:0]       match;
	logic [1:0]       ch_ev;
	logic [1:0]       fa;

	channel_if ch0 ();
	channel_if ch1 ();

	// set beats clear; the arm step is lost when a new event lands
	function automatic logic [1:0] flag_step(input logic flag, input logic arm,
		input logic ev, input logic rd, input logic clr, input logic ok);
		logic f;
		logic a;
		f = flag;
		a = arm;
		if (ok && rd && flag) begin
			a = 1'b1;
		end
		if (ok && clr && arm) begin
			f = 1'b0;
			a = 1'b0;
		end
		if (ev) begin
			f = 1'b1;
			a = 1'b0;
		end
		return {f, a};
	endfunction

	// ---------------------------------------------------------------
	// counter clocking
	// ---------------------------------------------------------------
	assign run = !counter_halt_bit_i && !stop_mode_i && !break_i;

	prescaler_tick u_presc (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clear_i (counter_clear_i),
		.run_i   (run),
		.sel_i   (prescale_sel_i),
		.tick_o  (tick)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_next   = st_reg;
		access_ok = !wait_mode_i;
		// with the permit low, break reads and writes leave flags alone
		clear_ok  = access_ok && (!break_i || break_clear_permit_i);
		linked    = pair_link_bit_i;
		at_limit  = (st_reg.cnt == period_limit_i);
		wrap_ev   = tick && at_limit && !counter_clear_i;
		cmp_a     = (linked && st_reg.act_sel) ? st_reg.cmp1 : st_reg.cmp0;
		// first channel in compare mode, or driven by the pair
		out_mode[0] = (linked || single_channel_select_i[0]) && (edge_level_select0_i != ELS_PORT);
		out_mode[1] = !linked && single_channel_select_i[1] && (edge_level_select1_i != ELS_PORT);
		// compare against the live register: no shadow in single mode
		match[0]  = tick && !counter_clear_i && (st_reg.cnt == cmp_a);
		match[1]  = tick && !counter_clear_i && !linked && (st_reg.cnt == st_reg.cmp1);
		ch_ev     = match & out_mode;

		if (counter_clear_i) begin
			st_next.cnt = CNT_RESET;
		end else if (tick) begin
			st_next.cnt = at_limit ? CNT_RESET : st_reg.cnt + CNT_W'(1);
		end

		fa = flag_step(st_reg.wrap_flag, st_reg.wrap_arm, wrap_ev,
			wrap_flag_read_i, wrap_flag_clear_i, clear_ok);
		st_next.wrap_flag = fa[1];
		st_next.wrap_arm  = fa[0];
		for (int i = 0; i < 2; i++) begin
			fa = flag_step(st_reg.ch_flag[i], st_reg.ch_arm[i], ch_ev[i],
				chan_flag_read_i[i], chan_flag_clear_i[i], clear_ok);
			st_next.ch_flag[i] = fa[1];
			st_next.ch_arm[i]  = fa[0];
		end

		if (access_ok && cmp_wr_i[0]) begin
			st_next.cmp0     = cmp_data_i;
			st_next.last_sel = 1'b0;
		end
		if (access_ok && cmp_wr_i[1]) begin
			st_next.cmp1     = cmp_data_i;
			st_next.last_sel = 1'b1;
		end
		if (!linked) begin
			// a fresh link always starts from the first pair
			st_next.act_sel  = 1'b0;
			st_next.last_sel = 1'b0;
		end else if (wrap_ev) begin
			st_next.act_sel = st_next.last_sel;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg      <= '0;
			st_reg.cmp0 <= CMP_RESET;
			st_reg.cmp1 <= CMP_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------
	// channel output stages
	// ---------------------------------------------------------------
	assign ch0.tick       = tick;
	assign ch0.wrap       = wrap_ev;
	assign ch0.match      = match[0];
	assign ch0.drive      = out_mode[0];
	assign ch0.preset_low = single_channel_select_i[0];
	assign ch0.els        = edge_level_select0_i;
	assign ch0.toggle_en  = wrap_toggle_enable_i[0];
	assign ch0.full_duty  = full_duty_select_i[0];

	assign ch1.tick       = tick;
	assign ch1.wrap       = wrap_ev && !linked;
	assign ch1.match      = match[1];
	assign ch1.drive      = out_mode[1];
	assign ch1.preset_low = single_channel_select_i[1];
	assign ch1.els        = edge_level_select1_i;
	assign ch1.toggle_en  = wrap_toggle_enable_i[1];
	assign ch1.full_duty  = full_duty_select_i[1];

	pwm_output_stage u_out0 (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ch    (ch0.stage)
	);

	pwm_output_stage u_out1 (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ch    (ch1.stage)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign counter_value_o         = st_reg.cnt;
	assign wrap_flag_o             = st_reg.wrap_flag;
	assign channel_event_flag_o    = st_reg.ch_flag;
	assign active_pair_o           = st_reg.act_sel;
	assign wrap_irq_o              = st_reg.wrap_flag && wrap_irq_enable_i;
	assign chan_irq_o              = st_reg.ch_flag & channel_irq_enable_i;
	assign wake_o                  = wait_mode_i && (wrap_irq_o || (|chan_irq_o));
	assign first_channel_pin_o     = ch0.pin;
	assign first_channel_pin_oe_o  = ch0.oe;
	assign second_channel_pin_o    = ch1.pin;
	assign second_channel_pin_oe_o = ch1.oe;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_wrap_read;
		wrap_flag_read_i && wrap_flag_o && clear_ok && !wrap_ev;
	endsequence

	sequence s_wrap_clear;
		wrap_flag_clear_i && clear_ok && !wrap_ev;
	endsequence

	sequence s_zero_duty_setup;
		out_mode[0] && !wrap_toggle_enable_i[0] && edge_level_select0_i == ELS_CLEAR;
	endsequence

	a_wrap_restart: assert property (
		wrap_ev |=> counter_value_o == CNT_RESET && wrap_flag_o)
		else $error("counter did not restart with flag at limit");

	a_flag_two_step: assert property (
		s_wrap_read ##1 s_wrap_clear |=> !wrap_flag_o)
		else $error("wrap flag not cleared by read then write");

	a_clear_needs_arm: assert property (
		wrap_flag_o && !st_reg.wrap_arm && !wrap_flag_read_i |=> wrap_flag_o)
		else $error("wrap flag cleared without prior read");

	a_break_protect: assert property (
		break_i && !break_clear_permit_i |=> $stable(st_reg.wrap_flag) || $past(wrap_ev))
		else $error("flag changed during protected break");

	a_break_freeze: assert property (
		break_i && !counter_clear_i |=> $stable(counter_value_o))
		else $error("counter moved during break");

	a_stop_hold: assert property (
		stop_mode_i && !counter_clear_i |=> $stable(counter_value_o))
		else $error("counter moved in stop mode");

	a_clear_zero: assert property (
		counter_clear_i |=> counter_value_o == CNT_RESET)
		else $error("counter clear did not zero counter");

	a_wait_locked: assert property (
		wait_mode_i |=> $stable(st_reg.cmp0) && $stable(st_reg.cmp1))
		else $error("compare written in wait mode");

	a_wrap_irq_gate: assert property (
		wrap_ev && wrap_irq_enable_i ##1 wrap_irq_enable_i |-> wrap_irq_o)
		else $error("enabled wrap did not request interrupt");

	a_link_handover: assert property (
		linked && st_next.last_sel && wrap_ev |=> active_pair_o)
		else $error("second pair did not take over at wrap");

	a_link_release: assert property (
		pair_link_bit_i ##1 pair_link_bit_i |-> !second_channel_pin_oe_o)
		else $error("second pin still driven while linked");

	a_zero_duty: assert property (
		(s_zero_duty_setup and !full_duty_select_i[0]) ##1
		(s_zero_duty_setup and match[0]) |=> !first_channel_pin_o)
		else $error("compare did not force low without toggle");

	a_full_duty: assert property (
		out_mode[0] && full_duty_select_i[0] && wrap_toggle_enable_i[0] &&
		edge_level_select0_i == ELS_CLEAR |=> first_channel_pin_o)
		else $error("full duty did not hold pulse level");

	a_chan_flag_set: assert property (
		ch_ev[0] |=> channel_event_flag_o[0])
		else $error("channel flag not set on compare");

	a_toggle_compare: assert property (
		out_mode[0] && match[0] && edge_level_select0_i == ELS_TOGGLE && !wrap_toggle_enable_i[0]
		|=> first_channel_pin_o != $past(first_channel_pin_o))
		else $error("pin did not toggle on compare");

	a_wrap_toggle: assert property (
		wrap_ev && out_mode[0] && wrap_toggle_enable_i[0] && !full_duty_select_i[0] && !match[0]
		|=> first_channel_pin_o != $past(first_channel_pin_o))
		else $error("pin did not toggle at wrap");

	a_cmp_write: assert property (
		access_ok && cmp_wr_i[0] |=> st_reg.cmp0 == $past(cmp_data_i))
		else $error("compare write lost");

	a_first_pair_stays: assert property (
		linked && !st_next.last_sel && wrap_ev |=> !active_pair_o)
		else $error("first pair lost control at wrap");

	a_count_step: assert property (
		tick && !at_limit && !counter_clear_i |=> counter_value_o == $past(counter_value_o) + CNT_W'(1))
		else $error("counter did not advance on tick");

endmodule

// >>> shared/timer_pkg.sv
/*
 * Shared constants and the state type of the channel output stage.
 * Assumes a single 10 MHz clock and a synchronous, active-high reset.
 */
package timer_pkg;

	// ---------------------------------------------------------------
	// widths, reset values and the no-source prescale code
	// ---------------------------------------------------------------
	localparam int          CNT_W       = 16;
	localparam int          DIV_W       = 6;
	localparam logic [15:0] CNT_RESET   = 16'h0000;
	localparam logic [15:0] CMP_RESET   = 16'h0000;
	localparam logic [5:0]  DIV_RESET   = 6'h00;
	localparam logic [2:0]  PS_NONE     = 3'h7;

	// ---------------------------------------------------------------
	// edge/level select codes for compare channels
	// ---------------------------------------------------------------
	localparam logic [1:0] ELS_PORT    = 2'h0;
	localparam logic [1:0] ELS_TOGGLE  = 2'h1;
	localparam logic [1:0] ELS_CLEAR   = 2'h2;
	localparam logic [1:0] ELS_SET     = 2'h3;

	typedef struct packed {
		logic pin;
		logic oe;
	} out_state_t;

endpackage

// >>> shared/channel_if.sv
/*
 * Carrier between the counter core and one channel output stage.
 * Assumes both ends share clk_i; all fields are same-cycle logic.
 */
interface channel_if;
	logic       tick;
	logic       wrap;
	logic       match;
	logic       drive;
	logic       preset_low;
	logic [1:0] els;
	logic       toggle_en;
	logic       full_duty;
	logic       pin;
	logic       oe;

	modport core (
		output tick, wrap, match, drive, preset_low, els, toggle_en, full_duty,
		input  pin, oe
	);
	modport stage (
		input  tick, wrap, match, drive, preset_low, els, toggle_en, full_duty,
		output pin, oe
	);
endinterface

// >>> rtl/prescaler_tick.sv
/*
 * Prescaler: divides the bus clock and emits one-cycle timer ticks.
 * Assumes clear and run come from logic on the same clock.
 */
module prescaler_tick import timer_pkg::*; (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       clear_i,
	input  wire logic       run_i,
	input  wire logic [2:0] sel_i,
	output logic            tick_o
);
	logic [DIV_W-1:0] div_reg;
	logic [DIV_W-1:0] div_next;
	logic [DIV_W-1:0] mask;

	function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] s);
		return DIV_W'((7'h01 << s) - 7'h01);
	endfunction

	always_comb begin
		mask     = div_mask(sel_i);
		// the unused select code never ticks, so the counter stays put
		tick_o   = run_i && (sel_i != PS_NONE) && ((div_reg & mask) == mask);
		div_next = div_reg;
		if (clear_i) begin
			div_next = DIV_RESET;
		end else if (run_i) begin
			div_next = div_reg + DIV_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= DIV_RESET;
		end else begin
			div_reg <= div_next;
		end
	end
endmodule

// >>> rtl/pwm_output_stage.sv
/*
 * One channel pin: toggle on wrap, forced level on compare, full duty.
 * Assumes the core only raises wrap and match together with tick.
 */
module pwm_output_stage import timer_pkg::*; (
	input  wire logic clk_i,
	input  wire logic rst_i,
	channel_if.stage  ch
);
	out_state_t st_reg;
	out_state_t st_next;

	always_comb begin
		st_next = st_reg;
		if (!ch.drive) begin
			// port owns the pin; keep the preset level ready for hand-over
			st_next.oe  = 1'b0;
			st_next.pin = !ch.preset_low;
		end else begin
			st_next.oe = 1'b1;
			if (ch.full_duty && ch.toggle_en) begin
				st_next.pin = !ch.els[0];
			end else begin
				if (ch.tick && ch.wrap && ch.toggle_en) begin
					st_next.pin = !st_reg.pin;
				end
				// compare acts after the wrap toggle in the same tick
				if (ch.tick && ch.match) begin
					case (ch.els)
						ELS_TOGGLE: st_next.pin = !st_next.pin;
						ELS_CLEAR:  st_next.pin = 1'b0;
						ELS_SET:    st_next.pin = 1'b1;
						default:    st_next.pin = st_next.pin;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ch.pin = st_reg.pin;
	assign ch.oe  = st_reg.oe;
endmodule

// >>> sim/pwm_load_model.sv
/*
 * Load on a channel pin: rebuilds the wire level and measures pulse high time and period.
 * Assumes the pin and its enable are registers on clk_i.
 */
module pwm_load_model (
	input  wire logic        clk_i,
	input  wire logic        pin_i,
	input  wire logic        oe_i,
	output logic             wire_o,
	output logic [15:0]      high_len_o,
	output logic [15:0]      period_len_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic        last = 1'b0;
	logic        prev = 1'b0;
	logic [15:0] run  = 16'h0000;

	// no pull on the line: a released pin shows the opposite of what was last driven
	assign wire_o = oe_i ? pin_i : ~last;

	initial begin
		high_len_o = 16'h0000;
		period_len_o = 16'h0000;
	end

	// ---------------------------------------------------------------
	// edge timing, counted in bus clocks
	// ---------------------------------------------------------------
	always @(posedge clk_i) begin
		if (oe_i)
			last <= pin_i;
		prev <= wire_o;
		run <= run + 16'h0001;
		if (wire_o && !prev) begin
			period_len_o <= run;
			run <= 16'h0001;
		end
		if (!wire_o && prev)
			high_len_o <= run;
	end
endmodule

// >>> sim/timer_pwm_channel_logic_tb.sv
/*
 * Self-checking bench for the two-channel timer: counter, flags, low-power, break, PWM, linked pair.
 * Assumes the hand-over timing: sel 0 ticks every cycle, outputs registered on the tick edge.
 */
module timer_pwm_channel_logic_tb;
	import timer_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             counter_halt_bit_i = 1'b1;
	logic             counter_clear_i = 1'b0;
	logic [2:0]       prescale_sel_i = 3'h0;
	logic [CNT_W-1:0] period_limit_i = 16'h0009;
	logic [CNT_W-1:0] cmp_data_i = 16'h0000;
	logic [1:0]       cmp_wr_i = 2'h0;
	logic [1:0]       single_channel_select_i = 2'h3;
	logic [1:0]       edge_level_select0_i = 2'h0;
	logic [1:0]       edge_level_select1_i = 2'h0;
	logic [1:0]       wrap_toggle_enable_i = 2'h0;
	logic [1:0]       full_duty_select_i = 2'h0;
	logic [1:0]       channel_irq_enable_i = 2'h0;
	logic [1:0]       chan_flag_read_i = 2'h0;
	logic [1:0]       chan_flag_clear_i = 2'h0;
	logic             wrap_irq_enable_i = 1'b0;
	logic             pair_link_bit_i = 1'b0;
	logic             wrap_flag_read_i = 1'b0;
	logic             wrap_flag_clear_i = 1'b0;
	logic             wait_mode_i = 1'b0;
	logic             stop_mode_i = 1'b0;
	logic             break_i = 1'b0;
	logic             break_clear_permit_i = 1'b0;
	logic [CNT_W-1:0] counter_value_o;
	logic [CNT_W-1:0] snap;
	logic             lvl;
	logic [15:0]      high_len;
	logic [15:0]      period_len;
	logic [1:0]       channel_event_flag_o;
	logic [1:0]       chan_irq_o;
	logic             wrap_flag_o, wrap_irq_o, wake_o, active_pair_o, load_wire;
	logic             first_channel_pin_o, first_channel_pin_oe_o, second_channel_pin_o, second_channel_pin_oe_o;
	int               err_total = 0;
	int               checked = 0;

	timer_pwm_channel_logic u_timer_pwm_channel_logic (.clk_i, .rst_i, .counter_halt_bit_i, .counter_clear_i,
		.prescale_sel_i, .period_limit_i, .wrap_irq_enable_i, .cmp_wr_i, .cmp_data_i, .pair_link_bit_i,
		.single_channel_select_i, .edge_level_select0_i, .edge_level_select1_i, .wrap_toggle_enable_i,
		.full_duty_select_i, .channel_irq_enable_i, .wrap_flag_read_i, .wrap_flag_clear_i, .chan_flag_read_i,
		.chan_flag_clear_i, .wait_mode_i, .stop_mode_i, .break_i, .break_clear_permit_i, .counter_value_o,
		.wrap_flag_o, .channel_event_flag_o, .wrap_irq_o, .chan_irq_o, .wake_o, .active_pair_o,
		.first_channel_pin_o, .first_channel_pin_oe_o, .second_channel_pin_o, .second_channel_pin_oe_o);

	pwm_load_model u_pwm_load_model (.clk_i(clk_i), .pin_i(first_channel_pin_o), .oe_i(first_channel_pin_oe_o),
		.wire_o(load_wire), .high_len_o(high_len), .period_len_o(period_len));

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// access tasks
	// ---------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic look;
		@(negedge clk_i);
	endtask

	task automatic chk(input logic ok, input string what);
		checked++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask

	// mask bit 2 is the wrap flag, bits 1:0 the channel flags
	task automatic rd(input logic [2:0] m);
		cyc(1);
		{wrap_flag_read_i, chan_flag_read_i} <= m;
		cyc(1);
		{wrap_flag_read_i, chan_flag_read_i} <= 3'h0;
	endtask

	// starts on the caller's edge, so a read just before it is one cycle earlier
	task automatic cl(input logic [2:0] m);
		{wrap_flag_clear_i, chan_flag_clear_i} <= m;
		cyc(1);
		{wrap_flag_clear_i, chan_flag_clear_i} <= 3'h0;
		look;
	endtask

	task automatic wcmp(input logic [1:0] ch, input logic [15:0] v);
		cyc(1);
		cmp_wr_i <= ch;
		cmp_data_i <= v;
		cyc(1);
		cmp_wr_i <= 2'h0;
	endtask

	task automatic wait_wrap;
		wait_ev(3'h4);
	endtask

	// same flag mask as rd; gives up after 50 cycles
	task automatic wait_ev(input logic [2:0] m);
		int n;
		n = 0;
		look;
		while (!(({wrap_flag_o, channel_event_flag_o} & m) == m) && n < 50) begin
			look;
			n++;
		end
		chk(({wrap_flag_o, channel_event_flag_o} & m) == m, "flag never set");
	endtask

	task automatic hold(input logic v, input int n);
		repeat (n) begin
			look;
			chk(first_channel_pin_o === v && first_channel_pin_oe_o === 1'b1, "pin level not held");
			chk(load_wire === v, "load sees wrong level");
		end
	endtask

	task automatic pwm_len(input logic [15:0] hi, input logic [15:0] per);
		cyc(35);
		look;
		chk(high_len === hi && period_len === per, "pulse width or period wrong");
	endtask

	task automatic give_verdict;
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		cyc(5000);
		err_total++;
		give_verdict;
	end

	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial begin
		cyc(2);
		rst_i <= 1'b0;
		look;
		chk(counter_value_o === 16'h0000 && wrap_flag_o === 1'b0 && channel_event_flag_o === 2'h0, "reset state");
		chk(first_channel_pin_oe_o === 1'b0 && active_pair_o === 1'b0, "reset pins");
		cyc(1);
		counter_clear_i <= 1'b1;
		cyc(1);
		counter_clear_i <= 1'b0;
		wcmp(2'h1, 16'h0003);
		edge_level_select0_i <= ELS_CLEAR;
		edge_level_select1_i <= ELS_CLEAR;
		wrap_toggle_enable_i <= 2'h3;
		cyc(1);
		counter_halt_bit_i <= 1'b0;
		pwm_len(16'h0004, 16'h000A);
		chk(second_channel_pin_oe_o === 1'b1, "second pin not driven");
		chk(wrap_flag_o === 1'b1 && channel_event_flag_o === 2'h3, "flags not set");
		chk(wrap_irq_o === 1'b0 && chan_irq_o === 2'h0, "irq while disabled");
		cyc(1);
		wrap_irq_enable_i <= 1'b1;
		channel_irq_enable_i <= 2'h1;
		wait_mode_i <= 1'b1;
		look;
		chk(wrap_irq_o === 1'b1 && chan_irq_o === 2'h1 && wake_o === 1'b1, "irq or wake missing");
		snap = counter_value_o;
		rd(3'h4);
		cl(3'h4);
		chk(wrap_flag_o === 1'b1 && counter_value_o !== snap, "wait mode access or counting");
		cyc(1);
		wait_mode_i <= 1'b0;
		counter_halt_bit_i <= 1'b1;
		cl(3'h7);
		chk(wrap_flag_o === 1'b1 && channel_event_flag_o === 2'h3, "clear without read took effect");
		rd(3'h7);
		cl(3'h7);
		chk(wrap_flag_o === 1'b0 && channel_event_flag_o === 2'h0 && wrap_irq_o === 1'b0, "flag clear");
		cyc(1);
		counter_halt_bit_i <= 1'b0;
		wait_wrap;
		cyc(1);
		counter_halt_bit_i <= 1'b1;
		rd(3'h4);
		break_i <= 1'b1;
		cl(3'h4);
		chk(wrap_flag_o === 1'b1, "flag cleared in break without permit");
		cyc(1);
		break_i <= 1'b0;
		cl(3'h4);
		chk(wrap_flag_o === 1'b0, "clear after break failed");
		cyc(1);
		counter_halt_bit_i <= 1'b0;
		wait_wrap;
		cyc(1);
		break_i <= 1'b1;
		break_clear_permit_i <= 1'b1;
		look;
		snap = counter_value_o;
		rd(3'h4);
		cl(3'h4);
		chk(wrap_flag_o === 1'b0 && counter_value_o === snap, "break permit or freeze");
		cyc(1);
		break_i <= 1'b0;
		break_clear_permit_i <= 1'b0;
		stop_mode_i <= 1'b1;
		cyc(2);
		look;
		snap = counter_value_o;
		cyc(5);
		look;
		chk(counter_value_o === snap, "counter moved in stop");
		cyc(1);
		stop_mode_i <= 1'b0;
		counter_clear_i <= 1'b1;
		cyc(1);
		counter_clear_i <= 1'b0;
		look;
		chk(counter_value_o === 16'h0000, "counter clear");
		cyc(1);
		prescale_sel_i <= 3'h7;
		counter_clear_i <= 1'b1;
		cyc(1);
		counter_clear_i <= 1'b0;
		cyc(4);
		look;
		chk(counter_value_o === 16'h0000, "counter ticked with no source");
		cyc(1);
		prescale_sel_i <= 3'h1;
		counter_clear_i <= 1'b1;
		cyc(1);
		counter_clear_i <= 1'b0;
		cyc(8);
		look;
		chk(counter_value_o === 16'h0004, "divide by two count");
		cyc(1);
		prescale_sel_i <= 3'h0;
		edge_level_select0_i <= ELS_SET;
		pwm_len(16'h0006, 16'h000A);
		cyc(1);
		edge_level_select0_i <= ELS_CLEAR;
		wrap_toggle_enable_i <= 2'h2;
		cyc(15);
		hold(1'b0, 12);
		cyc(1);
		wrap_toggle_enable_i <= 2'h3;
		full_duty_select_i <= 2'h3;
		cyc(15);
		hold(1'b1, 12);
		chk(second_channel_pin_o === 1'b1 && second_channel_pin_oe_o === 1'b1, "second pin full duty");
		cyc(1);
		full_duty_select_i <= 2'h0;
		rd(3'h4);
		cl(3'h4);
		rd(3'h4);
		cl(3'h4);
		wait_wrap;
		wcmp(2'h1, 16'h0005);
		pwm_len(16'h0006, 16'h000A);
		rd(3'h1);
		cl(3'h1);
		rd(3'h1);
		cl(3'h1);
		wait_ev(3'h1);
		wcmp(2'h1, 16'h0003);
		pwm_len(16'h0004, 16'h000A);
		cyc(1);
		pair_link_bit_i <= 1'b1;
		pwm_len(16'h0004, 16'h000A);
		chk(second_channel_pin_oe_o === 1'b0 && active_pair_o === 1'b0, "linked pin or pair");
		wcmp(2'h2, 16'h0006);
		pwm_len(16'h0007, 16'h000A);
		chk(active_pair_o === 1'b1, "second pair not active");
		wcmp(2'h1, 16'h0002);
		pwm_len(16'h0003, 16'h000A);
		chk(active_pair_o === 1'b0, "first pair not active");
		cyc(1);
		wrap_toggle_enable_i <= 2'h2;
		edge_level_select0_i <= ELS_TOGGLE;
		cyc(3);
		look;
		lvl = first_channel_pin_o;
		cyc(10);
		look;
		chk(first_channel_pin_o === !lvl && first_channel_pin_oe_o === 1'b1, "toggle on compare");
		give_verdict;
	end
endmodule
